/* rtl/gmii16_consts.svh */
// Named constants for the two-lane 16-bit interface and its serial line.
// Assumes inclusion by bare name from the package and the top module.
`ifndef GMII16_CONSTS_SVH
`define GMII16_CONSTS_SVH
`define LANE_BITS     8
`define WORD_BITS     16
`define UPPER_LANE    1
`define LOWER_LANE    0
`define FIRST_BIT_IDX 3'h0
`define LAST_BIT_IDX  3'h7
`define BIT_STEP      3'h1
`define BOTH_LANES    2'h3
`define UPPER_ONLY    2'h2
`define NO_LANES      2'h0
`define BYTE_ZERO     8'h00
`define WORD_ZERO     16'h0000
`define MIN_SYNC      2
`endif

/* rtl/gmii16_pkg.sv */
// Types shared by the lane interface: word carrier, line bits, tx states.
// Assumes the constants header is on the include path.
`default_nettype none
`include "gmii16_consts.svh"
package gmii16_pkg;

  typedef struct packed
  {
    logic [`WORD_BITS-1:0] data;
    logic [1:0]            valid;
    logic [1:0]            error;
  } lane_word_t;

  typedef struct packed
  {
    logic data;
    logic valid;
    logic error;
  } line_bits_t;

  typedef enum logic [2:0]
  {
    TX_IDLE  = 3'h1,
    TX_UPPER = 3'h2,
    TX_LOWER = 3'h4
  } tx_state_t;

endpackage : gmii16_pkg
`default_nettype wire

/* rtl/gmii16_phy_lane_interface.sv */
// Two-lane 16-bit MAC-facing interface with a bit-serial line on each side.
// Assumes the MAC runs on CLK_SYS; the receive line pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "gmii16_consts.svh"
module gmii16_phy_lane_interface
#(
  parameter int SYNC_STAGES = `MIN_SYNC
)
(
  input  wire logic                   CLK_SYS,
  input  wire logic                   RSTN,
  input  wire logic [`WORD_BITS-1:0]  TRANSMIT_WORD_IN,
  input  wire logic [1:0]             TRANSMIT_LANE_VALID,
  input  wire logic [1:0]             TRANSMIT_LANE_ERROR,
  output var  logic                   TRANSMIT_READY,
  output var  gmii16_pkg::line_bits_t LINE_TX_OUT,
  input  wire gmii16_pkg::line_bits_t LINE_RX_IN,
  output var  logic [`WORD_BITS-1:0]  RECEIVE_WORD_OUT,
  output var  logic [1:0]             RECEIVE_LANE_VALID,
  output var  logic [1:0]             RECEIVE_LANE_ERROR
);
  import gmii16_pkg::*;

  // ****************************************************************
  // Parameter check
  // ****************************************************************
  generate
    if (SYNC_STAGES < `MIN_SYNC)
    begin : bad_sync_stages
      $error("SYNC_STAGES must be at least two.");
    end
  endgenerate

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  function automatic logic is_last_lane(input tx_state_t s,
                                        input logic [1:0] v);
    is_last_lane = (s == TX_LOWER) ||
                   ((s == TX_UPPER) && !v[`LOWER_LANE]);
  endfunction : is_last_lane

  function automatic logic lane_bit(input lane_word_t w,
                                    input tx_state_t  s,
                                    input logic [2:0] b);
    logic [`LANE_BITS-1:0] sel;
    sel = (s == TX_UPPER) ? w.data[`WORD_BITS-1:`LANE_BITS]
                          : w.data[`LANE_BITS-1:0];
    lane_bit = sel[b];
  endfunction : lane_bit

  // ****************************************************************
  // Transmit serializer
  // ****************************************************************
  tx_state_t  tx_state_reg;
  tx_state_t  tx_state_next;
  lane_word_t tx_word_reg;
  lane_word_t tx_word_next;
  logic [2:0] tx_bit_reg;
  logic [2:0] tx_bit_next;
  logic       tx_ready_reg;
  logic       tx_ready_next;
  line_bits_t tx_line_reg;
  line_bits_t tx_line_next;
  logic       tx_take;
  lane_word_t tx_in_word;

  always_comb
  begin
    tx_in_word.data  = TRANSMIT_WORD_IN;
    tx_in_word.valid = TRANSMIT_LANE_VALID;
    tx_in_word.error = TRANSMIT_LANE_ERROR;
    tx_take       = tx_ready_reg && (|TRANSMIT_LANE_VALID);
    tx_state_next = tx_state_reg;
    tx_word_next  = tx_word_reg;
    tx_bit_next   = tx_bit_reg;
    if (tx_state_reg != TX_IDLE && tx_bit_reg != `LAST_BIT_IDX)
    begin
      tx_bit_next = tx_bit_reg + `BIT_STEP;
    end
    else if (tx_state_reg == TX_UPPER &&
             tx_word_reg.valid[`LOWER_LANE])
    begin
      tx_state_next = TX_LOWER;
      tx_bit_next   = `FIRST_BIT_IDX;
    end
    else if (tx_take)
    begin
      tx_word_next = tx_in_word;
      tx_bit_next  = `FIRST_BIT_IDX;
      if (TRANSMIT_LANE_VALID[`UPPER_LANE])
      begin
        tx_state_next = TX_UPPER;
      end
      else
      begin
        tx_state_next = TX_LOWER;
      end
    end
    else
    begin
      tx_state_next = TX_IDLE;
      tx_bit_next   = `FIRST_BIT_IDX;
    end
    // Ready is raised during the final bit so back-to-back words leave
    // no idle gap on the line, which the far end would read as frame end.
    tx_ready_next = (tx_state_next == TX_IDLE) ||
                    ((tx_bit_next == `LAST_BIT_IDX) &&
                     is_last_lane(tx_state_next, tx_word_next.valid));
    tx_line_next.valid = (tx_state_next != TX_IDLE);
    tx_line_next.data  = tx_line_next.valid &&
                         lane_bit(tx_word_next, tx_state_next, tx_bit_next);
    unique case (tx_state_next)
      TX_UPPER: tx_line_next.error = tx_word_next.error[`UPPER_LANE];
      TX_LOWER: tx_line_next.error = tx_word_next.error[`LOWER_LANE];
      TX_IDLE:  tx_line_next.error = 1'b0;
      default:  tx_line_next.error = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      tx_state_reg <= TX_IDLE;
      tx_word_reg  <= '0;
      tx_bit_reg   <= `FIRST_BIT_IDX;
      tx_ready_reg <= 1'b0;
      tx_line_reg  <= '0;
    end
    else
    begin
      tx_state_reg <= tx_state_next;
      tx_word_reg  <= tx_word_next;
      tx_bit_reg   <= tx_bit_next;
      tx_ready_reg <= tx_ready_next;
      tx_line_reg  <= tx_line_next;
    end
  end

  // ****************************************************************
  // Receive line synchronizer
  // ****************************************************************
  line_bits_t sync_reg  [SYNC_STAGES];
  line_bits_t sync_next [SYNC_STAGES];
  line_bits_t rx_line;

  assign sync_next[0] = LINE_RX_IN;
  genvar gi;
  generate
    for (gi = 1; gi < SYNC_STAGES; gi++)
    begin : sync_chain
      assign sync_next[gi] = sync_reg[gi-1];
    end
  endgenerate
  assign rx_line = sync_reg[SYNC_STAGES-1];

  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      for (int i = 0; i < SYNC_STAGES; i++)
      begin
        sync_reg[i] <= '0;
      end
    end
    else
    begin
      sync_reg <= sync_next;
    end
  end

  // ****************************************************************
  // Receive deserializer
  // ****************************************************************
  logic [2:0]            rx_bit_reg;
  logic [2:0]            rx_bit_next;
  logic [`LANE_BITS-1:0] rx_byte_reg;
  logic [`LANE_BITS-1:0] rx_byte_next;
  logic                  rx_berr_reg;
  logic                  rx_berr_next;
  logic                  rx_have_reg;
  logic                  rx_have_next;
  logic [`LANE_BITS-1:0] rx_upper_reg;
  logic [`LANE_BITS-1:0] rx_upper_next;
  logic                  rx_uerr_reg;
  logic                  rx_uerr_next;
  lane_word_t            rx_out_reg;
  lane_word_t            rx_out_next;
  logic                  rx_err_acc;

  always_comb
  begin
    rx_bit_next       = rx_bit_reg;
    rx_byte_next      = rx_byte_reg;
    rx_berr_next      = rx_berr_reg;
    rx_have_next      = rx_have_reg;
    rx_upper_next     = rx_upper_reg;
    rx_uerr_next      = rx_uerr_reg;
    rx_out_next       = rx_out_reg;
    rx_out_next.valid = `NO_LANES;
    rx_err_acc        = rx_berr_reg | rx_line.error;
    if (rx_line.valid)
    begin
      rx_byte_next[rx_bit_reg] = rx_line.data;
      if (rx_bit_reg == `LAST_BIT_IDX)
      begin
        rx_bit_next  = `FIRST_BIT_IDX;
        rx_berr_next = 1'b0;
        if (!rx_have_reg)
        begin
          rx_upper_next = rx_byte_next;
          rx_uerr_next  = rx_err_acc;
          rx_have_next  = 1'b1;
        end
        else
        begin
          rx_out_next.data  = {rx_upper_reg, rx_byte_next};
          rx_out_next.valid = `BOTH_LANES;
          rx_out_next.error = {rx_uerr_reg, rx_err_acc};
          rx_have_next      = 1'b0;
        end
      end
      else
      begin
        rx_bit_next  = rx_bit_reg + `BIT_STEP;
        rx_berr_next = rx_err_acc;
      end
    end
    else
    begin
      // A partial byte at frame end carries no data and is dropped.
      rx_bit_next  = `FIRST_BIT_IDX;
      rx_berr_next = 1'b0;
      if (rx_have_reg)
      begin
        rx_out_next.data  = {rx_upper_reg, `BYTE_ZERO};
        rx_out_next.valid = `UPPER_ONLY;
        rx_out_next.error = {rx_uerr_reg, 1'b0};
        rx_have_next      = 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      rx_bit_reg   <= `FIRST_BIT_IDX;
      rx_byte_reg  <= `BYTE_ZERO;
      rx_berr_reg  <= 1'b0;
      rx_have_reg  <= 1'b0;
      rx_upper_reg <= `BYTE_ZERO;
      rx_uerr_reg  <= 1'b0;
      rx_out_reg   <= '0;
    end
    else
    begin
      rx_bit_reg   <= rx_bit_next;
      rx_byte_reg  <= rx_byte_next;
      rx_berr_reg  <= rx_berr_next;
      rx_have_reg  <= rx_have_next;
      rx_upper_reg <= rx_upper_next;
      rx_uerr_reg  <= rx_uerr_next;
      rx_out_reg   <= rx_out_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Word and qualifiers aligned
  assign TRANSMIT_READY     = tx_ready_reg;
  assign LINE_TX_OUT        = tx_line_reg;
  assign RECEIVE_WORD_OUT   = rx_out_reg.data;
  assign RECEIVE_LANE_VALID = rx_out_reg.valid;
  assign RECEIVE_LANE_ERROR = rx_out_reg.error;

endmodule : gmii16_phy_lane_interface
`default_nettype wire

/* tb/gmii16_lane_checker.sv */
// Assertions on the ports of the lane interface.
// Assumes one clock domain; bound to every instance of the top module.
`timescale 1ns/1ps
`default_nettype none
module gmii16_lane_checker
#(
  parameter int SYNC_STAGES = 2
)
(
  input wire logic                   CLK_SYS,
  input wire logic                   RSTN,
  input wire logic [15:0]            TRANSMIT_WORD_IN,
  input wire logic [1:0]             TRANSMIT_LANE_VALID,
  input wire logic [1:0]             TRANSMIT_LANE_ERROR,
  input wire logic                   TRANSMIT_READY,
  input wire gmii16_pkg::line_bits_t LINE_TX_OUT,
  input wire gmii16_pkg::line_bits_t LINE_RX_IN,
  input wire logic [15:0]            RECEIVE_WORD_OUT,
  input wire logic [1:0]             RECEIVE_LANE_VALID,
  input wire logic [1:0]             RECEIVE_LANE_ERROR
);
  import gmii16_pkg::*;
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RSTN);
  sequence s_up;
    TRANSMIT_READY && TRANSMIT_LANE_VALID[1];
  endsequence
  sequence s_both;
    TRANSMIT_READY && TRANSMIT_LANE_VALID == 2'h3;
  endsequence
  property p_up_first;
    s_up |=> LINE_TX_OUT.valid &&
      LINE_TX_OUT.data == $past(TRANSMIT_WORD_IN[8]);
  endproperty
  a_up_first: assert property (p_up_first)
    else $error("upper byte not first");
  property p_lsb_first;
    s_up |-> ##2 LINE_TX_OUT.data == $past(TRANSMIT_WORD_IN[9], 2);
  endproperty
  a_lsb_first: assert property (p_lsb_first)
    else $error("bit 9 not second");
  property p_low_after;
    s_both |-> ##9 LINE_TX_OUT.valid &&
      LINE_TX_OUT.data == $past(TRANSMIT_WORD_IN[0], 9);
  endproperty
  a_low_after: assert property (p_low_after)
    else $error("lower byte not after upper");
  property p_low_only;
    TRANSMIT_READY && TRANSMIT_LANE_VALID == 2'h1 |=>
      LINE_TX_OUT.data == $past(TRANSMIT_WORD_IN[0]) &&
      LINE_TX_OUT.error == $past(TRANSMIT_LANE_ERROR[0]);
  endproperty
  a_low_only: assert property (p_low_only)
    else $error("lower-only word wrong");
  property p_up_err;
    s_up |=> LINE_TX_OUT.error == $past(TRANSMIT_LANE_ERROR[1]);
  endproperty
  a_up_err: assert property (p_up_err)
    else $error("upper error not sent");
  property p_busy;
    s_both |=> !TRANSMIT_READY [*8];
  endproperty
  a_busy: assert property (p_busy)
    else $error("ready during word");
  property p_idle;
    TRANSMIT_READY && TRANSMIT_LANE_VALID == 2'h0 |=> !LINE_TX_OUT.valid;
  endproperty
  a_idle: assert property (p_idle)
    else $error("unqualified word sent");
  property p_rx_pulse;
    RECEIVE_LANE_VALID != 2'h0 |->
      RECEIVE_LANE_VALID[1] ##1 RECEIVE_LANE_VALID == 2'h0;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse)
    else $error("bad receive valid");
  property p_rx_odd;
    RECEIVE_LANE_VALID == 2'h2 |->
      !RECEIVE_LANE_ERROR[0] && RECEIVE_WORD_OUT[7:0] == 8'h00;
  endproperty
  a_rx_odd: assert property (p_rx_odd)
    else $error("odd byte lower lane not clear");
  property p_rx_hold;
    RECEIVE_LANE_VALID == 2'h0 |-> $stable(RECEIVE_WORD_OUT);
  endproperty
  a_rx_hold: assert property (p_rx_hold)
    else $error("receive word moved");
  property p_rx_latency;
    RECEIVE_LANE_VALID != 2'h0 |->
      $past(LINE_RX_IN.valid, SYNC_STAGES + 1) == RECEIVE_LANE_VALID[0];
  endproperty
  a_rx_latency: assert property (p_rx_latency)
    else $error("receive word at wrong cycle");
endmodule : gmii16_lane_checker
bind gmii16_phy_lane_interface gmii16_lane_checker
  #(.SYNC_STAGES(SYNC_STAGES)) chk_i (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
  .TRANSMIT_WORD_IN(TRANSMIT_WORD_IN),
  .TRANSMIT_LANE_VALID(TRANSMIT_LANE_VALID),
  .TRANSMIT_LANE_ERROR(TRANSMIT_LANE_ERROR),
  .TRANSMIT_READY(TRANSMIT_READY), .LINE_TX_OUT(LINE_TX_OUT),
  .LINE_RX_IN(LINE_RX_IN), .RECEIVE_WORD_OUT(RECEIVE_WORD_OUT),
  .RECEIVE_LANE_VALID(RECEIVE_LANE_VALID),
  .RECEIVE_LANE_ERROR(RECEIVE_LANE_ERROR));
`default_nettype wire

/* tb/mac_model.sv */
// Behavioural MAC that offers words and holds each until taken.
// Assumes callers enter just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module mac_model
(
  input  wire logic       clk,
  input  wire logic       ready,
  output var logic [15:0] word,
  output var logic [1:0]  valid,
  output var logic [1:0]  error
);
  initial
  begin
    word = 16'h0000;
    valid = 2'h0;
    error = 2'h0;
  end
  task automatic send(input logic [15:0] d, input logic [1:0] v,
                      input logic [1:0] e);
    // Idle data toggles so a stale word is never mistaken for a new one.
    word = (v == 2'h0) ? ~word : d;
    valid = v;
    error = e;
    while (ready !== 1'b1)
      @(posedge clk) #1;
    @(posedge clk) #1;
  endtask : send
endmodule : mac_model
`default_nettype wire

/* tb/test_gmii16_phy_lane_interface.sv */
// Loopback bench: transmit line feeds receive line, model predicts words.
// Assumes the MAC model and checker are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module test_gmii16_phy_lane_interface;
  import gmii16_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic [15:0] tx_word;
  logic [1:0]  tx_valid;
  logic [1:0]  tx_err;
  logic        tx_ready;
  line_bits_t  tx_line;
  logic [15:0] rx_word;
  logic [1:0]  rx_valid;
  logic [1:0]  rx_err;
  logic [19:0] exp_q[$];
  logic [8:0]  pend;
  logic        has_pend = 1'b0;
  logic [31:0] seed = 32'h741A;
  int          failures = 0;
  int          n_checks = 0;
  always #50 clk_sys = ~clk_sys;
  mac_model mac_model_i (.clk(clk_sys), .ready(tx_ready), .word(tx_word),
    .valid(tx_valid), .error(tx_err));
  gmii16_phy_lane_interface gmii16_phy_lane_interface_i (.CLK_SYS(clk_sys),
    .RSTN(rstn), .TRANSMIT_WORD_IN(tx_word), .TRANSMIT_LANE_VALID(tx_valid),
    .TRANSMIT_LANE_ERROR(tx_err), .TRANSMIT_READY(tx_ready),
    .LINE_TX_OUT(tx_line), .LINE_RX_IN(tx_line), .RECEIVE_WORD_OUT(rx_word),
    .RECEIVE_LANE_VALID(rx_valid), .RECEIVE_LANE_ERROR(rx_err));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // Bytes pair up in arrival order; the first of a pair is the upper lane.
  task automatic add(input logic [8:0] b);
    if (has_pend)
      exp_q.push_back({pend[8:1], b[8:1], 2'h3, pend[0], b[0]});
    else
      pend = b;
    has_pend = !has_pend;
  endtask : add
  task automatic frame(input int n);
    logic [15:0] d;
    logic [1:0]  v;
    logic [1:0]  e;
    for (int i = 0; i < n; i++)
    begin
      d = 16'(rnd());
      e = 2'(rnd());
      v = 2'h3;
      if (i == 0 && rnd() > 32'h7FFFFFFF)
        v = 2'h1;
      if (i > 0 && i == n - 1 && rnd() > 32'h7FFFFFFF)
        v = 2'h2;
      if (v[1])
        add({d[15:8], e[1]});
      if (v[0])
        add({d[7:0], e[0]});
      mac_model_i.send(d, v, e);
    end
    mac_model_i.send(16'h0000, 2'h0, 2'h0);
    if (has_pend)
      exp_q.push_back({pend[8:1], 8'h00, 2'h2, pend[0], 1'b0});
    has_pend = 1'b0;
  endtask : frame
  task automatic stop_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  always @(negedge clk_sys)
    if (rstn === 1'b1 && rx_valid !== 2'h0)
      check({4'h0, rx_word, rx_valid, rx_err},
            {4'h0, exp_q.pop_front()});
  initial
  begin
    #2_000_000;
    failures++;
    stop_test();
  end
  initial
  begin
    repeat (2) @(posedge clk_sys);
    #1 rstn = 1'b1;
    for (int k = 0; k < 30; k++)
    begin
      frame(int'(rnd() % 32'h6) + 1);
      if (k == 15)
      begin
        repeat (30) @(posedge clk_sys);
        #1 rstn = 1'b0;
        #1 check({tx_ready, tx_line, rx_word, rx_valid, rx_err},
                 24'h0);
        repeat (2) @(posedge clk_sys);
        #1 rstn = 1'b1;
        @(posedge clk_sys) #1 check(24'(tx_ready), 24'h1);
      end
    end
    repeat (40) @(posedge clk_sys);
    check(24'(exp_q.size()), 24'h0);
    stop_test();
  end
endmodule : test_gmii16_phy_lane_interface
`default_nettype wire
